// File: src/qsr_status_top.sv
`timescale 1ns/1ps
// Overview of operation
// - preset loads all enable masks, including the operation mask, with ones
// - preset loads rising filters with ones and falling filters with zeros
// - preset touches only filters, masks and queue enable, never conditions or events
// - a condition read returns live status and changes nothing
// - an event read returns latched bits and clears that event part
// - an enabled event bit raises the parent summary; masked bits do not
// - first limit feeds bit 10 of doubtful_result_status; second feeds limit one bit 0
// - with the falling filter bit set, a falling condition edge sets the event
// - with the rising filter bit set, a rising condition edge sets the event
// - register enable masks and both filters are 16 bits wide, any value accepted; the operation mask is only loaded by preset
// - two independent limit registers, each complete, chosen by an index
// - a queue query returns the oldest error entry and removes it
// - an empty queue answers error number 0 with the no-error text
// - each entry holds a signed error number and a short text
// - the clear-status command clears every event part and the error queue, and a hardware reset clears them too; preset does not
module qsr_status_top
    import qsr_pkg::*;
#(
    parameter int QUEUE_DEPTH = QSR_QUEUE_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire qsr_cmd_type i_cmd,
    input wire qsr_cond_type i_cond,
    input wire qsr_err_type i_err,
    output qsr_rsp_type o_rsp,
    output logic o_summary,
    output logic [15:0] o_oper_enable,
    output logic o_queue_enable
);
    localparam int PTR_W = $clog2(QUEUE_DEPTH);
    localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(QUEUE_DEPTH);

    function automatic logic [15:0] put_bit(input logic [15:0] v, input int pos, input logic b);
        logic [15:0] r;
        r = v;
        r[pos] = b;
        return r;
    endfunction : put_bit

    function automatic logic cmd_is(input qsr_cmd_type c, input qsr_op_type op);
        return c.valid && (c.op == op);
    endfunction : cmd_is

    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    wire [15:0] raw_cond [QSR_NREG];
    assign raw_cond[0] = i_cond.quest;
    assign raw_cond[1] = i_cond.integ;
    assign raw_cond[2] = i_cond.hw;
    assign raw_cond[3] = i_cond.lim1;
    assign raw_cond[4] = i_cond.lim2;

    // a bit is set only once two late stages agree on one and is cleared as soon as they differ, so a one-cycle high glitch cannot make an edge
    logic [15:0] sync1_ff [QSR_NREG];
    logic [15:0] sync2_ff [QSR_NREG];
    logic [15:0] sync3_ff [QSR_NREG];
    logic [15:0] stab_ff [QSR_NREG];
    wire [15:0] cond_in [QSR_NREG];
    wire [15:0] event_out [QSR_NREG];
    wire [15:0] rise_out [QSR_NREG];
    wire [QSR_NREG-1:0] summary;

    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            for (int i = 0; i < QSR_NREG; i++) begin
                sync1_ff[i] <= 16'h0000;
                sync2_ff[i] <= 16'h0000;
                sync3_ff[i] <= 16'h0000;
                stab_ff[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < QSR_NREG; i++) begin
                sync1_ff[i] <= raw_cond[i];
                sync2_ff[i] <= sync1_ff[i];
                sync3_ff[i] <= sync2_ff[i];
                stab_ff[i] <= (stab_ff[i] & ~(sync2_ff[i] ^ sync3_ff[i]))
                    | (sync2_ff[i] & ~(sync2_ff[i] ^ sync3_ff[i]));
            end
        end
    end

    assign cond_in[QSR_IDX_QUEST] = put_bit(put_bit(stab_ff[QSR_IDX_QUEST], QSR_BIT_QUEST_LIM1,
        summary[QSR_IDX_LIM1]), QSR_BIT_QUEST_INTEG, summary[QSR_IDX_INTEG]);
    assign cond_in[QSR_IDX_INTEG] = put_bit(stab_ff[QSR_IDX_INTEG], QSR_BIT_INTEG_HW,
        summary[QSR_IDX_HW]);
    assign cond_in[QSR_IDX_HW] = stab_ff[QSR_IDX_HW];
    assign cond_in[QSR_IDX_LIM1] = put_bit(stab_ff[QSR_IDX_LIM1], QSR_BIT_LIM1_LIM2,
        summary[QSR_IDX_LIM2]);
    assign cond_in[QSR_IDX_LIM2] = stab_ff[QSR_IDX_LIM2];

    wire preset = cmd_is(i_cmd, QSR_OP_PRESET);
    wire clear_all = cmd_is(i_cmd, QSR_OP_CLEAR);

    for (genvar g = 0; g < QSR_NREG; g++) begin : g_reg
        wire hit = i_cmd.sel == 3'(g);
        qsr_status_reg u_reg (
            .i_clk(i_clk),
            .i_rst_n(rst_n_ff),
            .i_cond(cond_in[g]),
            .i_wdata(i_cmd.data),
            .i_we_enable(hit && cmd_is(i_cmd, QSR_OP_WR_ENABLE)),
            .i_we_rise(hit && cmd_is(i_cmd, QSR_OP_WR_RISE)),
            .i_we_fall(hit && cmd_is(i_cmd, QSR_OP_WR_FALL)),
            .i_preset(preset),
            .i_ev_clr(clear_all || (hit && cmd_is(i_cmd, QSR_OP_READ_EVENT))),
            .o_event(event_out[g]),
            .o_rise(rise_out[g]),
            .o_summary(summary[g])
        );
    end

    // error queue, storage in flip-flops
    logic signed [15:0] num_mem_ff [QUEUE_DEPTH];
    logic [31:0] text_mem_ff [QUEUE_DEPTH];
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W:0] count_ff;
    logic queue_en_ff;
    logic [15:0] oper_en_ff;
    logic summary_ff;
    qsr_rsp_type rsp_ff;

    wire query = cmd_is(i_cmd, QSR_OP_QUEUE_QUERY);
    wire queue_empty = count_ff == '0;
    wire pop = query && !queue_empty && !clear_all;
    // a full queue drops the newest arrival unless a query pops in the same cycle; a clear-status in the same cycle drops it too
    wire push = i_err.push && !clear_all && ((count_ff != DEPTH_CNT) || pop);
    wire [PTR_W:0] nxt_count = clear_all ? '0 : (count_ff + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop));
    wire [PTR_W-1:0] nxt_rd_ptr = clear_all ? '0 : (pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff);
    wire [PTR_W-1:0] nxt_wr_ptr = clear_all ? '0 : (push ? wr_ptr_ff + 1'b1 : wr_ptr_ff);

    wire sel_ok = i_cmd.sel < 3'(QSR_NREG);
    wire [15:0] rd_cond = sel_ok ? cond_in[i_cmd.sel] : 16'h0000;
    wire [15:0] rd_event = sel_ok ? event_out[i_cmd.sel] : 16'h0000;
    wire read_cond = cmd_is(i_cmd, QSR_OP_READ_COND);
    wire read_event = cmd_is(i_cmd, QSR_OP_READ_EVENT);
    wire qsr_rsp_type nxt_rsp;
    assign nxt_rsp.valid = read_cond || read_event || query;
    assign nxt_rsp.data = read_cond ? rd_cond : (read_event ? rd_event : 16'h0000);
    assign nxt_rsp.err_num = pop ? num_mem_ff[rd_ptr_ff] : QSR_NO_ERROR_NUM;
    assign nxt_rsp.err_text = pop ? text_mem_ff[rd_ptr_ff] : (query ? QSR_NO_ERROR_TEXT : 32'h0);

    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            for (int i = 0; i < QUEUE_DEPTH; i++) begin
                num_mem_ff[i] <= 16'sh0000;
                text_mem_ff[i] <= 32'h00000000;
            end
        end else if (push) begin
            num_mem_ff[wr_ptr_ff] <= i_err.num;
            text_mem_ff[wr_ptr_ff] <= i_err.text;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rd_ptr_ff <= '0;
            wr_ptr_ff <= '0;
            count_ff <= '0;
            queue_en_ff <= QSR_QUEUE_EN_RST;
            oper_en_ff <= QSR_ENABLE_RST;
            summary_ff <= 1'b0;
            rsp_ff <= '0;
        end else begin
            rd_ptr_ff <= nxt_rd_ptr;
            wr_ptr_ff <= nxt_wr_ptr;
            count_ff <= nxt_count;
            queue_en_ff <= queue_en_ff | preset;
            oper_en_ff <= preset ? QSR_ENABLE_PRESET : oper_en_ff;
            summary_ff <= summary[QSR_IDX_QUEST];
            rsp_ff <= nxt_rsp;
        end
    end

    assign o_rsp = rsp_ff;
    assign o_summary = summary_ff;
    assign o_oper_enable = oper_en_ff;
    assign o_queue_enable = queue_en_ff;

    a_queue_empty: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
        query && queue_empty |=> o_rsp.valid && (o_rsp.err_num == 16'sh0000)
        && (o_rsp.err_text == QSR_NO_ERROR_TEXT))
        else $error("empty queue answer wrong");
    a_queue_pop: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
        pop && !push |=> count_ff == $past(count_ff) - 1'b1)
        else $error("query did not remove an entry");
    a_limit_chain: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
        $rose(summary[QSR_IDX_LIM2]) && rise_out[QSR_IDX_LIM1][0] && !clear_all
        |=> event_out[QSR_IDX_LIM1][0])
        else $error("second limit summary did not reach limit one bit 0");
    a_cond_read: assert property (@(posedge i_clk) disable iff (!rst_n_ff)
        read_cond && sel_ok |=> o_rsp.valid && (o_rsp.data == $past(rd_cond)))
        else $error("condition read returned wrong data");
endmodule : qsr_status_top

// File: src/qsr_pkg.sv
package qsr_pkg;
    localparam int QSR_WIDTH = 16;
    localparam int QSR_NREG = 5;
    // register indices, also the value of the select field of a command
    localparam logic [2:0] QSR_IDX_QUEST = 3'h0;
    localparam logic [2:0] QSR_IDX_INTEG = 3'h1;
    localparam logic [2:0] QSR_IDX_HW = 3'h2;
    localparam logic [2:0] QSR_IDX_LIM1 = 3'h3;
    localparam logic [2:0] QSR_IDX_LIM2 = 3'h4;
    // summary bit positions in the parent condition parts
    localparam int QSR_BIT_QUEST_LIM1 = 10;
    localparam int QSR_BIT_QUEST_INTEG = 9;
    localparam int QSR_BIT_INTEG_HW = 2;
    localparam int QSR_BIT_LIM1_LIM2 = 0;
    // values after hardware reset and after preset
    localparam logic [15:0] QSR_ENABLE_RST = 16'h0000;
    localparam logic [15:0] QSR_RISE_RST = 16'hFFFF;
    localparam logic [15:0] QSR_FALL_RST = 16'h0000;
    localparam logic [15:0] QSR_ENABLE_PRESET = 16'hFFFF;
    localparam logic [15:0] QSR_RISE_PRESET = 16'hFFFF;
    localparam logic [15:0] QSR_FALL_PRESET = 16'h0000;
    localparam logic QSR_QUEUE_EN_RST = 1'b0;
    // error queue
    localparam int QSR_QUEUE_DEPTH = 8;
    localparam logic signed [15:0] QSR_NO_ERROR_NUM = 16'sh0000;
    // four ascii characters "NOER", the no-error description
    localparam logic [31:0] QSR_NO_ERROR_TEXT = 32'h4E4F4552;

    typedef enum logic [3:0] {
        QSR_OP_NONE,
        QSR_OP_READ_COND,
        QSR_OP_READ_EVENT,
        QSR_OP_WR_ENABLE,
        QSR_OP_WR_RISE,
        QSR_OP_WR_FALL,
        QSR_OP_PRESET,
        QSR_OP_CLEAR,
        QSR_OP_QUEUE_QUERY
    } qsr_op_type;

    typedef struct packed {
        logic valid;
        qsr_op_type op;
        logic [2:0] sel;
        logic [15:0] data;
    } qsr_cmd_type;

    typedef struct packed {
        logic [15:0] quest;
        logic [15:0] integ;
        logic [15:0] hw;
        logic [15:0] lim1;
        logic [15:0] lim2;
    } qsr_cond_type;

    typedef struct packed {
        logic push;
        logic signed [15:0] num;
        logic [31:0] text;
    } qsr_err_type;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
        logic signed [15:0] err_num;
        logic [31:0] err_text;
    } qsr_rsp_type;
endpackage : qsr_pkg

// File: src/qsr_status_reg.sv
`timescale 1ns/1ps
module qsr_status_reg
    import qsr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_cond,
    input wire logic [15:0] i_wdata,
    input wire logic i_we_enable,
    input wire logic i_we_rise,
    input wire logic i_we_fall,
    input wire logic i_preset,
    input wire logic i_ev_clr,
    output logic [15:0] o_event,
    output logic [15:0] o_rise,
    output logic o_summary
);
    logic [15:0] prev_ff;
    logic [15:0] event_ff;
    logic [15:0] enable_ff;
    logic [15:0] rise_ff;
    logic [15:0] fall_ff;

    wire [15:0] rise_hit = i_cond & ~prev_ff & rise_ff;
    wire [15:0] fall_hit = ~i_cond & prev_ff & fall_ff;
    wire [15:0] set_bits = rise_hit | fall_hit;
    // clear on read, a new edge wins over the clear
    wire [15:0] nxt_event = (i_ev_clr ? 16'h0000 : event_ff) | set_bits;
    wire [15:0] nxt_enable = i_preset ? QSR_ENABLE_PRESET : (i_we_enable ? i_wdata : enable_ff);
    wire [15:0] nxt_rise = i_preset ? QSR_RISE_PRESET : (i_we_rise ? i_wdata : rise_ff);
    wire [15:0] nxt_fall = i_preset ? QSR_FALL_PRESET : (i_we_fall ? i_wdata : fall_ff);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_ff <= 16'h0000;
            event_ff <= 16'h0000;
            enable_ff <= QSR_ENABLE_RST;
            rise_ff <= QSR_RISE_RST;
            fall_ff <= QSR_FALL_RST;
        end else begin
            prev_ff <= i_cond;
            event_ff <= nxt_event;
            enable_ff <= nxt_enable;
            rise_ff <= nxt_rise;
            fall_ff <= nxt_fall;
        end
    end

    assign o_event = event_ff;
    assign o_rise = rise_ff;
    assign o_summary = |(event_ff & enable_ff);

    a_preset_fill: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_preset |=> (enable_ff == 16'hFFFF) && (rise_ff == 16'hFFFF) && (fall_ff == 16'h0000))
        else $error("preset did not load masks and filters");
    a_preset_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_preset && !i_ev_clr |=> event_ff == ($past(event_ff) | $past(set_bits)))
        else $error("preset disturbed event bits");
    a_read_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ev_clr && (set_bits == 16'h0000) |=> event_ff == 16'h0000)
        else $error("event read did not clear");
    a_rise_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ##1 ((i_cond & ~$past(i_cond) & rise_ff) != 16'h0000)
        |=> (event_ff & $past(i_cond & ~prev_ff & rise_ff)) == $past(i_cond & ~prev_ff & rise_ff))
        else $error("rising edge not latched");
    a_fall_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ((~i_cond & prev_ff & fall_ff) != 16'h0000)
        |=> (event_ff & $past(~i_cond & prev_ff & fall_ff)) == $past(~i_cond & prev_ff & fall_ff))
        else $error("falling edge not latched");
    a_event_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_ev_clr |=> (event_ff & $past(event_ff)) == $past(event_ff))
        else $error("event bit dropped without a clear");
    a_summary_mask: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ((set_bits & enable_ff) != 16'h0000) && !i_we_enable |=> o_summary)
        else $error("enabled event did not raise summary");
endmodule : qsr_status_reg

// File: tb/qsr_host_model.sv
`timescale 1ns/1ps
module qsr_host_model
    import qsr_pkg::*;
(
    input wire logic i_clk,
    input wire qsr_rsp_type i_rsp,
    output qsr_cmd_type o_cmd
);
    initial begin
        o_cmd = '0;
    end

    // one command a call; the answer is taken 1 ns after the taking edge
    task automatic send(input qsr_op_type op, input logic [2:0] sel, input logic [15:0] data,
            output qsr_rsp_type rsp);
        @(posedge i_clk);
        #1;
        o_cmd = '{1'b1, op, sel, data};
        @(posedge i_clk);
        #1;
        rsp = i_rsp;
        // released fields turn over so a stale value never passes for a live one
        o_cmd = '{1'b0, QSR_OP_NONE, ~sel, ~data};
    endtask : send
endmodule : qsr_host_model

// File: tb/test_doubtful_result_status_status_reporting.sv
`timescale 1ns/1ps
module test_doubtful_result_status_status_reporting;
    import qsr_pkg::*;
    typedef struct {
        logic [2:0] sel;
        logic [15:0] rise, fall, pat, cnd, up, dn;
    } qsr_row_type;
    logic i_clk;
    logic i_reset_n;
    qsr_cmd_type cmd;
    qsr_cond_type cond;
    qsr_err_type err;
    qsr_rsp_type rsp;
    qsr_rsp_type r;
    logic summary;
    logic queue_en;
    logic [15:0] oper_en;
    int failures = 0;
    int tests_run = 0;
    // patterns keep clear of the bit positions that summaries overlay
    qsr_row_type rows [6] = '{
        '{QSR_IDX_QUEST, 16'hFFFF, 16'h0000, 16'hF0F0, 16'hF0F0, 16'hF0F0, 16'h0000},
        '{QSR_IDX_INTEG, 16'h0000, 16'hFFFF, 16'h8001, 16'h8001, 16'h0000, 16'h8001},
        '{QSR_IDX_HW, 16'h00FF, 16'hFF00, 16'h0FF0, 16'h0FF0, 16'h00F0, 16'h0F00},
        '{QSR_IDX_LIM1, 16'hA5A5, 16'h5A5A, 16'hFFFE, 16'hFFFE, 16'hA5A4, 16'h5A5A},
        '{QSR_IDX_LIM2, 16'h1234, 16'h8421, 16'hFFFF, 16'hFFFF, 16'h1234, 16'h8421},
        '{3'h5, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000}};

    qsr_status_top #(.QUEUE_DEPTH(2)) uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd(cmd),
        .i_cond(cond), .i_err(err), .o_rsp(rsp), .o_summary(summary),
        .o_oper_enable(oper_en), .o_queue_enable(queue_en));
    qsr_host_model host (.i_clk(i_clk), .i_rsp(rsp), .o_cmd(cmd));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc

    task automatic go(input qsr_op_type op, input logic [2:0] sel, input logic [15:0] d);
        host.send(op, sel, d, r);
    endtask : go

    // pins pass a three-flop synchroniser, so allow settling before looking
    task automatic pin(input logic [2:0] sel, input logic [15:0] v);
        @(posedge i_clk);
        #1;
        case (sel)
            QSR_IDX_QUEST: cond.quest = v;
            QSR_IDX_INTEG: cond.integ = v;
            QSR_IDX_HW: cond.hw = v;
            QSR_IDX_LIM1: cond.lim1 = v;
            QSR_IDX_LIM2: cond.lim2 = v;
            default: ;
        endcase
        cyc(8);
    endtask : pin

    task automatic push(input logic signed [15:0] num, input logic [31:0] txt);
        @(posedge i_clk);
        #1;
        err = '{1'b1, num, txt};
        @(posedge i_clk);
        #1;
        err.push = 1'b0;
    endtask : push

    task automatic results();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    initial begin
        #(5000 * 20);
        failures++;
        results();
    end

    initial begin
        i_reset_n = 1'b0;
        cond = '0;
        err = '0;
        repeat (5) @(posedge i_clk);
        #1;
        // outputs idle while reset is held
        chk({rsp.valid, summary, oper_en, queue_en}, 19'h00000);
        i_reset_n = 1'b1;
        cyc(3);
        foreach (rows[i]) begin
            go(QSR_OP_WR_RISE, rows[i].sel, rows[i].rise);
            go(QSR_OP_WR_FALL, rows[i].sel, rows[i].fall);
            pin(rows[i].sel, rows[i].pat);
            go(QSR_OP_READ_COND, rows[i].sel, 16'h0000);
            chk({r.valid, r.data}, {1'b1, rows[i].cnd});
            go(QSR_OP_READ_COND, rows[i].sel, 16'h0000);
            chk(r.data, rows[i].cnd);
            go(QSR_OP_READ_EVENT, rows[i].sel, 16'h0000);
            chk(r.data, rows[i].up);
            go(QSR_OP_READ_EVENT, rows[i].sel, 16'h0000);
            chk(r.data, 16'h0000);
            pin(rows[i].sel, 16'h0000);
            go(QSR_OP_READ_EVENT, rows[i].sel, 16'h0000);
            chk(r.data, rows[i].dn);
        end
        pin(QSR_IDX_LIM2, 16'h0004);
        go(QSR_OP_READ_COND, QSR_IDX_LIM1, 16'h0000);
        chk(r.data, 16'h0000);
        go(QSR_OP_WR_ENABLE, QSR_IDX_LIM2, 16'h0004);
        go(QSR_OP_WR_ENABLE, QSR_IDX_LIM1, 16'h0001);
        go(QSR_OP_WR_ENABLE, QSR_IDX_QUEST, 16'h0400);
        pin(QSR_IDX_LIM2, 16'h0000);
        cyc(8);
        chk(summary, 1'b1);
        go(QSR_OP_READ_COND, QSR_IDX_LIM1, 16'h0000);
        chk(r.data, 16'h0001);
        go(QSR_OP_READ_COND, QSR_IDX_QUEST, 16'h0000);
        chk(r.data, 16'h0400);
        go(QSR_OP_READ_EVENT, QSR_IDX_LIM2, 16'h0000);
        chk(r.data, 16'h0004);
        go(QSR_OP_CLEAR, 3'h0, 16'h0000);
        cyc(12);
        chk(summary, 1'b0);
        go(QSR_OP_WR_FALL, QSR_IDX_QUEST, 16'hFFFF);
        pin(QSR_IDX_QUEST, 16'h0030);
        go(QSR_OP_PRESET, 3'h0, 16'h0000);
        cyc(4);
        chk({oper_en, queue_en, summary}, {16'hFFFF, 2'b11});
        go(QSR_OP_READ_COND, QSR_IDX_QUEST, 16'h0000);
        chk(r.data, 16'h0030);
        go(QSR_OP_READ_EVENT, QSR_IDX_QUEST, 16'h0000);
        chk(r.data, 16'h0030);
        pin(QSR_IDX_QUEST, 16'h0000);
        pin(QSR_IDX_HW, 16'hFF00);
        // hardware summary rises through signal_soundness_status bit 2 into doubtful_result_status bit 9
        go(QSR_OP_READ_EVENT, QSR_IDX_QUEST, 16'h0000);
        chk(r.data, 16'h0200);
        go(QSR_OP_READ_EVENT, QSR_IDX_HW, 16'h0000);
        chk(r.data, 16'hFF00);
        // oldest first, depth two drops the third
        go(QSR_OP_QUEUE_QUERY, 3'h0, 16'h0000);
        chk({r.err_num, r.err_text}, {QSR_NO_ERROR_NUM, QSR_NO_ERROR_TEXT});
        push(16'hFFFB, 32'h45525231);
        push(16'h0007, 32'h45525232);
        push(16'h0009, 32'h45525233);
        go(QSR_OP_QUEUE_QUERY, 3'h0, 16'h0000);
        chk({r.err_num, r.err_text}, {16'hFFFB, 32'h45525231});
        go(QSR_OP_QUEUE_QUERY, 3'h0, 16'h0000);
        chk({r.err_num, r.err_text}, {16'h0007, 32'h45525232});
        go(QSR_OP_QUEUE_QUERY, 3'h0, 16'h0000);
        chk({r.err_num, r.err_text}, {QSR_NO_ERROR_NUM, QSR_NO_ERROR_TEXT});
        results();
    end
endmodule : test_doubtful_result_status_status_reporting
